// File: cwd_pkg.sv
`default_nettype none
package cwd_pkg;
  // Byte offsets on the register bus
  localparam logic [4:0] CWD_OFF_WINDOW = 5'h00;
  localparam logic [4:0] CWD_OFF_SEED = 5'h04;
  localparam logic [4:0] CWD_OFF_REPLY = 5'h08;
  localparam logic [4:0] CWD_OFF_CTRL = 5'h0C;
  localparam logic [4:0] CWD_OFF_STATUS = 5'h10;
  // 16-bit register contents sit in data bits 23:8
  localparam int CWD_FIELD_LSB = 8;
  localparam int CWD_FIELD_W = 16;
  // Window configuration field positions inside the 16-bit value
  localparam int CWD_PERIOD_LSB = 12;
  localparam int CWD_DUTY_LSB = 8;
  localparam int CWD_RECOV_LSB = 0;
  localparam logic [15:0] CWD_WINDOW_RST = 16'h320B;
  localparam logic [15:0] CWD_WINDOW_MASK = 16'hF70F;
  localparam logic [15:0] CWD_SEED_RST = 16'h5AB2;
  localparam logic [15:0] CWD_REPLY_RST = 16'h0000;
  localparam logic [15:0] CWD_SIMPLE_REPLY = 16'h5AB2;
  // Expected challenger reply arithmetic
  localparam logic [15:0] CWD_MUL = 16'h0004;
  localparam logic [15:0] CWD_ADD = 16'h0006;
  localparam logic [15:0] CWD_SUB = 16'h0004;
  localparam logic [15:0] CWD_DIV = 16'h0004;
  // Control and status bits
  localparam int CWD_CTRL_SIMPLE_BIT = 0;
  localparam int CWD_STAT_GOOD_BIT = 0;
  localparam int CWD_STAT_BAD_BIT = 1;
  localparam int CWD_STAT_GCNT_LSB = 8;
  localparam int CWD_STAT_BCNT_LSB = 16;
  localparam logic [1:0] CWD_RESP_OKAY = 2'h0;
  localparam logic [1:0] CWD_RESP_SLVERR = 2'h2;
  typedef enum {CWD_REG_WINDOW, CWD_REG_SEED, CWD_REG_REPLY, CWD_REG_CTRL,
    CWD_REG_STATUS, CWD_REG_NONE} cwd_reg_t;
endpackage
`default_nettype wire

// File: cwd_reply_check.sv
`timescale 1ns/100ps
`default_nettype none
module cwd_reply_check
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Reply written by software
  input wire logic i_reply_strobe,
  input wire logic [15:0] i_reply_value,
  input wire logic [15:0] i_seed,
  input wire logic i_simple_mode,
  // Classification pulses
  output logic o_good,
  output logic o_bad
);
  import cwd_pkg::*;

  logic good_reg;
  logic good_next;
  logic bad_reg;
  logic bad_next;
  logic [15:0] expected;

  // Challenger answer, every step kept to 16 bits
  function automatic logic [15:0] challenger_answer(input logic [15:0] seed);
    logic [15:0] t;
    t = 16'((seed * CWD_MUL) + CWD_ADD - CWD_SUB);
    return 16'((~t) / CWD_DIV);
  endfunction

  always_comb
  begin
    expected = i_simple_mode ? CWD_SIMPLE_REPLY : challenger_answer(i_seed); // [R3] [R4]
    good_next = i_reply_strobe && (i_reply_value == expected); // [R5]
    bad_next = i_reply_strobe && (i_reply_value != expected); // [R5]
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      good_reg <= 1'b0;
      bad_reg <= 1'b0;
    end
    else
    begin
      good_reg <= good_next;
      bad_reg <= bad_next;
    end
  end

  assign o_good = good_reg;
  assign o_bad = bad_reg;
endmodule
`default_nettype wire

// File: cwd_regs.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] Holds a readable, writable 16-bit seed starting from 0x5AB2 at reset.
// [R2] Write-only 16-bit reply register in data bits 23:8, cleared at reset.
// [R3] Challenger reply is NOT((seed*4+6)-4)/4 on 16 bits.
// [R4] Simple mode expects the fixed reply 0x5AB2.
// [R5] Every reply write is classed as a good or bad refresh.
module cwd_regs
#(
  parameter int ADDR_W = 5
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // AXI4-Lite write address and data
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Watchdog configuration and refresh results
  output logic [3:0] o_window_period_sel,
  output logic [2:0] o_window_duty_sel,
  output logic [3:0] o_recovery_window_sel,
  output logic o_refresh_good,
  output logic o_refresh_bad
);
  import cwd_pkg::*;

  if (ADDR_W < 5)
  begin : g_addr_check
    $error("cwd_regs: ADDR_W must be at least 5");
  end

  // Bus channel state
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Register state
  logic [15:0] window_reg, window_next;
  logic [15:0] seed_reg, seed_next;
  logic [15:0] reply_reg, reply_next;
  logic simple_reg, simple_next;
  logic last_good_reg, last_good_next, last_bad_reg, last_bad_next;
  logic [7:0] good_cnt_reg, good_cnt_next, bad_cnt_reg, bad_cnt_next;
  logic reply_strobe_reg, reply_strobe_next;
  logic do_write;
  cwd_reg_t wsel;
  cwd_reg_t rsel;
  logic chk_good, chk_bad;

  function automatic cwd_reg_t decode(input logic [ADDR_W-1:0] addr);
    logic [4:0] a;
    a = addr[4:0];
    if ((addr >> 5) != '0 || a[1:0] != 2'h0)
      return CWD_REG_NONE;
    unique case (a)
      CWD_OFF_WINDOW: return CWD_REG_WINDOW;
      CWD_OFF_SEED: return CWD_REG_SEED;
      CWD_OFF_REPLY: return CWD_REG_REPLY;
      CWD_OFF_CTRL: return CWD_REG_CTRL;
      CWD_OFF_STATUS: return CWD_REG_STATUS;
      default: return CWD_REG_NONE;
    endcase
  endfunction

  // Byte-lane merge of a 16-bit field held in data bits 23:8
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
    input logic [3:0] s);
    logic [15:0] r;
    r = old;
    for (int b = 0; b < 2; b++)
      if (s[b+1])
        r[b*8 +: 8] = d[CWD_FIELD_LSB + b*8 +: 8];
    return r;
  endfunction

  // Write channel
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wsel = decode(awaddr_reg);
    if (i_s_axi_awvalid && awready_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = i_s_axi_wdata;
      wstrb_next = i_s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == CWD_REG_NONE) ? CWD_RESP_SLVERR : CWD_RESP_OKAY;
    end
    else if (bvalid_reg && i_s_axi_bready)
      bvalid_next = 1'b0;
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  // Register file and refresh bookkeeping
  always_comb
  begin
    window_next = window_reg;
    seed_next = seed_reg;
    reply_next = reply_reg;
    simple_next = simple_reg;
    reply_strobe_next = 1'b0;
    last_good_next = last_good_reg;
    last_bad_next = last_bad_reg;
    good_cnt_next = good_cnt_reg;
    bad_cnt_next = bad_cnt_reg;
    if (do_write)
    begin
      unique case (wsel)
        CWD_REG_WINDOW: window_next = merge16(window_reg, wdata_reg, wstrb_reg) & CWD_WINDOW_MASK;
        CWD_REG_SEED: seed_next = merge16(seed_reg, wdata_reg, wstrb_reg); // [R1]
        CWD_REG_REPLY:
        begin
          reply_next = merge16(reply_reg, wdata_reg, wstrb_reg); // [R2]
          reply_strobe_next = 1'b1; // [R5]
        end
        CWD_REG_CTRL:
          if (wstrb_reg[0])
            simple_next = wdata_reg[CWD_CTRL_SIMPLE_BIT];
        CWD_REG_STATUS, CWD_REG_NONE:
        begin
        end
      endcase
    end
    if (chk_good || chk_bad)
    begin
      last_good_next = chk_good; // [R5]
      last_bad_next = chk_bad;
      good_cnt_next = good_cnt_reg + 8'(chk_good);
      bad_cnt_next = bad_cnt_reg + 8'(chk_bad);
    end
  end

  // Read channel; the reply register reads as zero
  always_comb
  begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rsel = decode(i_s_axi_araddr);
    if (i_s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rdata_next = 32'h0000_0000;
      rresp_next = CWD_RESP_OKAY;
      unique case (rsel)
        CWD_REG_WINDOW: rdata_next[CWD_FIELD_LSB +: CWD_FIELD_W] = window_reg;
        CWD_REG_SEED: rdata_next[CWD_FIELD_LSB +: CWD_FIELD_W] = seed_reg; // [R1]
        CWD_REG_REPLY: rdata_next = 32'h0000_0000; // [R2]
        CWD_REG_CTRL: rdata_next[CWD_CTRL_SIMPLE_BIT] = simple_reg;
        CWD_REG_STATUS:
        begin
          rdata_next[CWD_STAT_GOOD_BIT] = last_good_reg;
          rdata_next[CWD_STAT_BAD_BIT] = last_bad_reg;
          rdata_next[CWD_STAT_GCNT_LSB +: 8] = good_cnt_reg;
          rdata_next[CWD_STAT_BCNT_LSB +: 8] = bad_cnt_reg;
        end
        CWD_REG_NONE: rresp_next = CWD_RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && i_s_axi_rready)
    begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CWD_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= CWD_RESP_OKAY;
      window_reg <= CWD_WINDOW_RST;
      seed_reg <= CWD_SEED_RST; // [R1]
      reply_reg <= CWD_REPLY_RST; // [R2]
      simple_reg <= 1'b0;
      reply_strobe_reg <= 1'b0;
      last_good_reg <= 1'b0;
      last_bad_reg <= 1'b0;
      good_cnt_reg <= 8'h00;
      bad_cnt_reg <= 8'h00;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      window_reg <= window_next;
      seed_reg <= seed_next;
      reply_reg <= reply_next;
      simple_reg <= simple_next;
      reply_strobe_reg <= reply_strobe_next;
      last_good_reg <= last_good_next;
      last_bad_reg <= last_bad_next;
      good_cnt_reg <= good_cnt_next;
      bad_cnt_reg <= bad_cnt_next;
    end
  end

  cwd_reply_check u_check
  (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_reply_strobe(reply_strobe_reg),
    .i_reply_value(reply_reg),
    .i_seed(seed_reg),
    .i_simple_mode(simple_reg),
    .o_good(chk_good),
    .o_bad(chk_bad)
  );

  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready = wready_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_window_period_sel = window_reg[CWD_PERIOD_LSB +: 4];
  assign o_window_duty_sel = window_reg[CWD_DUTY_LSB +: 3];
  assign o_recovery_window_sel = window_reg[CWD_RECOV_LSB +: 4];
  assign o_refresh_good = chk_good;
  assign o_refresh_bad = chk_bad;
endmodule
`default_nettype wire

// File: cwd_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module cwd_regs_props
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Bus handshakes
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  // Refresh results
  input wire logic o_refresh_good,
  input wire logic o_refresh_bad
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  ar_to_r_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data not held");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response not held");
  pulse_excl_a: assert property (!(o_refresh_good && o_refresh_bad))
    else $error("good and bad together");
  pulse_once_a: assert property (o_refresh_good || o_refresh_bad
    |=> !(o_refresh_good || o_refresh_bad))
    else $error("refresh pulse too long");
  pulse_src_a: assert property (o_refresh_good || o_refresh_bad |-> $past(o_s_axi_bvalid))
    else $error("refresh pulse without write");
endmodule
bind cwd_regs cwd_regs_props i_cwd_regs_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_refresh_good(o_refresh_good), .o_refresh_bad(o_refresh_bad));
`default_nettype wire

// File: tb_cwd_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cwd_regs;
  import cwd_pkg::*;
  logic clk = 1'b0, rstn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, good, bad;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hF, per, rec;
  logic [2:0] duty;
  logic [1:0] br, rr;
  int mismatches = 0, tests_run = 0, cyc = 0, ng = 0, nb = 0;
  cwd_regs i_cwd_regs (.i_sys_clk(clk), .i_rstn(rstn), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .i_s_axi_arprot(3'h0), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_window_period_sel(per),
    .o_window_duty_sel(duty), .o_recovery_window_sel(rec),
    .o_refresh_good(good), .o_refresh_bad(bad));
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    ng += (good === 1'b1);
    nb += (bad === 1'b1);
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr_rdy)
        wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, er}, "write resp");
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    chk(rd, e, "read data");
    chk({30'h0, rr}, {30'h0, er}, "read resp");
  endtask
  function automatic logic [15:0] exp_ch(input logic [15:0] s);
    logic [15:0] t;
    t = s * 16'h4 + 16'h6 - 16'h4;
    return (~t) >> 2;
  endfunction
  task automatic refresh(input logic [15:0] v, input logic ok);
    int g0;
    int b0;
    g0 = ng;
    b0 = nb;
    wr(CWD_OFF_REPLY, {8'h00, v, 8'h00}, CWD_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(ng - g0, {31'h0, ok}, "good count");
    chk(nb - b0, {31'h0, !ok}, "bad count");
  endtask
  task automatic t_reset();
    rdc(CWD_OFF_SEED, 32'h005AB200, CWD_RESP_OKAY);
    rdc(CWD_OFF_REPLY, 32'h0, CWD_RESP_OKAY);
    rdc(CWD_OFF_WINDOW, 32'h00320B00, CWD_RESP_OKAY);
    chk({21'h0, per, duty, rec}, {21'h0, 4'h3, 3'h2, 4'hB}, "window outputs");
    rdc(5'h14, 32'h0, CWD_RESP_SLVERR);
    wr(5'h14, 32'hFFFFFFFF, CWD_RESP_SLVERR);
  endtask
  task automatic t_window();
    wr(CWD_OFF_WINDOW, 32'hFFFFFFFF, CWD_RESP_OKAY);
    rdc(CWD_OFF_WINDOW, 32'h00F70F00, CWD_RESP_OKAY);
    chk({21'h0, per, duty, rec}, {21'h0, 4'hF, 3'h7, 4'hF}, "window outputs");
  endtask
  task automatic t_challenger();
    wr(CWD_OFF_SEED, 32'h00123400, CWD_RESP_OKAY);
    rdc(CWD_OFF_SEED, 32'h00123400, CWD_RESP_OKAY);
    refresh(exp_ch(16'h1234), 1'b1);
    refresh(exp_ch(16'h1234) ^ 16'h1, 1'b0);
    refresh(16'h5AB2, 1'b0);
    wr(CWD_OFF_SEED, 32'h00FFFF00, CWD_RESP_OKAY);
    refresh(exp_ch(16'hFFFF), 1'b1);
    rdc(CWD_OFF_REPLY, 32'h0, CWD_RESP_OKAY);
  endtask
  task automatic t_simple();
    wr(CWD_OFF_CTRL, 32'h1, CWD_RESP_OKAY);
    rdc(CWD_OFF_CTRL, 32'h1, CWD_RESP_OKAY);
    refresh(16'h5AB2, 1'b1);
    refresh(exp_ch(16'hFFFF), 1'b0);
    wr(CWD_OFF_CTRL, 32'h0, CWD_RESP_OKAY);
    refresh(exp_ch(16'hFFFF), 1'b1);
    rdc(CWD_OFF_STATUS, 32'h00030401, CWD_RESP_OKAY);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_window();
    t_challenger();
    t_simple();
    end_sim();
  end
endmodule
`default_nettype wire
